// ==== mbc_consts.svh ====
// named offsets, reset values, field positions and codes of the config registers
`ifndef MBC_CONSTS_SVH
`define MBC_CONSTS_SVH
`define MBC_IDX_CLOCK_DIVISOR 8'h01
`define MBC_IDX_MEMORY_CONTROL 8'h04
`define MBC_IDX_SHIFT 2
`define MBC_CLKDIV_RESET 8'h22
`define MBC_CLKDIV_WMASK 8'h6F
`define MBC_MEMCTL_RESET 8'h70
`define MBC_GLOBAL_MAP_ENABLE_BIT 7
`define MBC_BANK_MSB 6
`define MBC_BANK_LSB 4
`define MBC_TYPE_MSB 3
`define MBC_TYPE_LSB 0
`define MBC_ISA_CLOCK_DIVISOR_SEL_MSB 1
`define MBC_ISA_CLOCK_DIVISOR_SEL_LSB 0
`define MBC_BANK_RESERVED 3'h7
`define MBC_BANK_MAX_VALID 3'h5
`define MBC_ISA_CLOCK_DIVISOR_SEL_DIV4 2'h0
`define MBC_ISA_CLOCK_DIVISOR_SEL_DIV3 2'h1
`define MBC_ISA_CLOCK_DIVISOR_SEL_DIV2 2'h2
`define MBC_ISA_CLOCK_DIVISOR_SEL_RESERVED 2'h3
`define MBC_HTRANS_NONSEQ 2'h2
`define MBC_HSIZE_WORD 3'h2
`define MBC_DISP_SHIFT 17
`endif

// ==== mbc_pkg.sv ====
// types shared by the memory and bus configuration block
package mbc_pkg;
  typedef struct packed {
    logic globalMapEnable;
    logic [2:0] bankCount;
    logic [3:0] ramTypeSelect;
  } mbc_mem_ctl_t;
  typedef struct packed {
    logic [5:0] ramBankSelect;
    logic memoryChipSelect;
    logic flashCycle;
  } mbc_decode_t;
  typedef enum logic [0:0] {
    MBC_IDLE = 1'b0,
    MBC_DATA = 1'b1
  } mbc_bus_state_t;
endpackage

// ==== mbc_isa_clock_divider.sv ====
// isa bus clock divider from the processor clock
`timescale 1ns/1ns
`include "mbc_consts.svh"
module mbc_isa_clock_divider (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [1:0] isaClockDivisorSel,
  output logic isaClk
);
  logic [2:0] count;
  logic [2:0] divisor;
  logic [2:0] next_count;
  logic [2:0] next_divisor;
  logic next_isaClk;

  function automatic logic [2:0] divFor(input logic [1:0] sel);
    unique case (sel)
      `MBC_ISA_CLOCK_DIVISOR_SEL_DIV4: divFor = 3'h4;
      `MBC_ISA_CLOCK_DIVISOR_SEL_DIV3: divFor = 3'h3;
      `MBC_ISA_CLOCK_DIVISOR_SEL_DIV2: divFor = 3'h2;
      default: divFor = 3'h2;
    endcase
  endfunction

  // new divisor taken only at a period boundary
  always_comb begin
    next_divisor = divisor;
    next_count = count + 3'h1;
    if (count == divisor - 3'h1) begin
      next_count = 3'h0;
      next_divisor = divFor(isaClockDivisorSel);
    end
    next_isaClk = (next_count < (next_divisor >> 1));
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count <= 3'h0;
      divisor <= 3'h2;
      isaClk <= 1'b1;
    end else begin
      count <= next_count;
      divisor <= next_divisor;
      isaClk <= next_isaClk;
    end
  end
endmodule // mbc_isa_clock_divider

// ==== mbc_config_regs.sv ====
// memory control and isa clock divisor registers on ahb-lite with ram decode
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "mbc_consts.svh"
module mbc_config_regs #(
  parameter int ADDR_W = 27
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic memReq,
  input wire logic [ADDR_W-1:0] memAddr,
  output logic [5:0] ramBankSelect,
  output logic memoryChipSelect,
  output logic flashCycle,
  output logic globalMapEnable,
  output logic [3:0] ramTypeSelect,
  output logic [ADDR_W-1:0] displayBufferBase,
  output logic configValid,
  output logic [1:0] isaClockDivisorSel,
  output logic isaClk
);
  mbc_pkg::mbc_bus_state_t state;
  mbc_pkg::mbc_bus_state_t next_state;
  logic [7:0] clockDivisorBusControl;
  logic [7:0] next_clockDivisorBusControl;
  mbc_pkg::mbc_mem_ctl_t memoryControlOne;
  mbc_pkg::mbc_mem_ctl_t next_memoryControlOne;
  logic pendWrite;
  logic next_pendWrite;
  logic [7:0] pendIndex;
  logic [7:0] next_pendIndex;
  logic [31:0] next_hrdata;
  mbc_pkg::mbc_decode_t next_decode;
  logic [ADDR_W-1:0] next_displayBufferBase;
  logic next_configValid;
  logic [4:0] bankShift;
  logic [ADDR_W:0] ramTop;
  logic [ADDR_W:0] bankIndexWide;
  logic staticRam;
  logic addrPhase;

  // log2 of one sixteen-bit-wide bank in bytes, zero for reserved types
  function automatic logic [4:0] shiftFor(input logic [3:0] ramType);
    unique case (ramType)
      4'h1: shiftFor = 5'h12;
      4'h2: shiftFor = 5'h14;
      4'h4: shiftFor = 5'h12;
      4'h5: shiftFor = 5'h14;
      4'h7: shiftFor = 5'h14;
      4'h8: shiftFor = 5'h15;
      4'h9: shiftFor = 5'h17;
      4'hA: shiftFor = 5'h13;
      4'hB: shiftFor = 5'h15;
      4'hC: shiftFor = 5'h16;
      default: shiftFor = 5'h00;
    endcase
  endfunction

  function automatic logic isStatic(input logic [3:0] ramType);
    isStatic = (ramType == 4'h1) || (ramType == 4'h2) ||
      (ramType == 4'h4) || (ramType == 4'h5);
  endfunction

  function automatic logic [7:0] readValue(
    input logic [7:0] index,
    input logic [7:0] clkReg,
    input mbc_pkg::mbc_mem_ctl_t memReg
  );
    if (index == `MBC_IDX_CLOCK_DIVISOR) begin
      readValue = clkReg;
    end else if (index == `MBC_IDX_MEMORY_CONTROL) begin
      readValue = memReg;
    end else begin
      readValue = 8'h00;
    end
  endfunction

  assign addrPhase = hsel && hready && (htrans == `MBC_HTRANS_NONSEQ);

  // bus slave and register file
  always_comb begin
    next_state = state;
    next_pendWrite = 1'b0;
    next_pendIndex = pendIndex;
    next_hrdata = hrdata;
    next_clockDivisorBusControl = clockDivisorBusControl;
    next_memoryControlOne = memoryControlOne;
    if (state == mbc_pkg::MBC_DATA && pendWrite) begin
      if (pendIndex == `MBC_IDX_CLOCK_DIVISOR) begin
        next_clockDivisorBusControl = hwdata[7:0] & `MBC_CLKDIV_WMASK;
      end else if (pendIndex == `MBC_IDX_MEMORY_CONTROL) begin
        next_memoryControlOne = hwdata[7:0];
      end
    end
    if (addrPhase) begin
      next_state = mbc_pkg::MBC_DATA;
      next_pendIndex = (haddr[1:0] == 2'h0 && hsize == `MBC_HSIZE_WORD &&
        haddr[31:10] == 22'h000000) ? haddr[9:`MBC_IDX_SHIFT] : 8'hFF;
      next_pendWrite = hwrite;
      next_hrdata = {24'h000000, readValue(next_pendIndex,
        next_clockDivisorBusControl, next_memoryControlOne)};
    end else if (hready) begin
      next_state = mbc_pkg::MBC_IDLE;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= mbc_pkg::MBC_IDLE;
      pendWrite <= 1'b0;
      pendIndex <= 8'hFF;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      clockDivisorBusControl <= `MBC_CLKDIV_RESET;
      memoryControlOne <= `MBC_MEMCTL_RESET;
    end else begin
      state <= next_state;
      pendWrite <= next_pendWrite;
      pendIndex <= next_pendIndex;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      clockDivisorBusControl <= next_clockDivisorBusControl;
      memoryControlOne <= next_memoryControlOne;
    end
  end

  // ram geometry from the stored configuration
  always_comb begin
    bankShift = shiftFor(memoryControlOne.ramTypeSelect);
    staticRam = isStatic(memoryControlOne.ramTypeSelect);
    ramTop = ({{ADDR_W{1'b0}}, 1'b0} + (ADDR_W + 1)'(memoryControlOne.bankCount) +
      (ADDR_W + 1)'(1)) << bankShift;
    bankIndexWide = {1'b0, memAddr} >> bankShift;
    next_configValid = (bankShift != 5'h00) &&
      (memoryControlOne.bankCount <= `MBC_BANK_MAX_VALID);
  end

  // address decode and display buffer placement
  always_comb begin
    next_decode = '0;
    next_displayBufferBase = '0;
    if (next_configValid) begin
      next_displayBufferBase = ADDR_W'(ramTop -
        ((ADDR_W + 1)'(1) << `MBC_DISP_SHIFT));
      if (memReq) begin
        if ({1'b0, memAddr} < ramTop) begin
          next_decode.ramBankSelect = 6'h01 << bankIndexWide[2:0];
        end else if (staticRam) begin
          next_decode.memoryChipSelect = 1'b1;
          next_decode.flashCycle = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      displayBufferBase <= '0;
      configValid <= 1'b0;
      ramBankSelect <= 6'h00;
      memoryChipSelect <= 1'b0;
      flashCycle <= 1'b0;
      globalMapEnable <= 1'b0;
      ramTypeSelect <= 4'h0;
      isaClockDivisorSel <= `MBC_ISA_CLOCK_DIVISOR_SEL_DIV2;
    end else begin
      displayBufferBase <= next_displayBufferBase;
      configValid <= next_configValid;
      ramBankSelect <= next_decode.ramBankSelect;
      memoryChipSelect <= next_decode.memoryChipSelect;
      flashCycle <= next_decode.flashCycle;
      globalMapEnable <= memoryControlOne.globalMapEnable;
      ramTypeSelect <= memoryControlOne.ramTypeSelect;
      isaClockDivisorSel <= clockDivisorBusControl[`MBC_ISA_CLOCK_DIVISOR_SEL_MSB:`MBC_ISA_CLOCK_DIVISOR_SEL_LSB];
    end
  end

  mbc_isa_clock_divider isaDivider (
    .core_clk(core_clk),
    .reset(reset),
    .isaClockDivisorSel(clockDivisorBusControl[`MBC_ISA_CLOCK_DIVISOR_SEL_MSB:`MBC_ISA_CLOCK_DIVISOR_SEL_LSB]),
    .isaClk(isaClk)
  );
endmodule // mbc_config_regs

// ==== mbc_config_regs_props.sv ====
// concurrent checks on the memory and bus config register ports
`timescale 1ns/1ns
`include "mbc_consts.svh"
module mbc_config_regs_props #(
  parameter int ADDR_W = 27
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic memReq,
  input wire logic [5:0] ramBankSelect,
  input wire logic memoryChipSelect,
  input wire logic flashCycle,
  input wire logic globalMapEnable,
  input wire logic [3:0] ramTypeSelect,
  input wire logic [ADDR_W-1:0] displayBufferBase,
  input wire logic configValid,
  input wire logic [1:0] isaClockDivisorSel,
  input wire logic isaClk
);
  logic [2:0] wrAge;
  logic [2:0] next_wrAge;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  // cycles since the last write was taken
  always_comb begin
    next_wrAge = (wrAge == 3'h7) ? wrAge : wrAge + 3'h1;
    if (hsel && hready && hwrite && htrans == `MBC_HTRANS_NONSEQ) begin
      next_wrAge = 3'h0;
    end
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wrAge <= 3'h7;
    end else begin
      wrAge <= next_wrAge;
    end
  end
  chk_div_two: assert property (
    (isaClockDivisorSel == `MBC_ISA_CLOCK_DIVISOR_SEL_DIV2)[*4] |-> isaClk != $past(isaClk))
    else $error("isa clock not halved");
  chk_div_three: assert property (
    (isaClockDivisorSel == `MBC_ISA_CLOCK_DIVISOR_SEL_DIV3)[*8] |->
      isaClk == $past(isaClk, 3) && !(isaClk && $past(isaClk)))
    else $error("isa clock not divided by three");
  chk_div_four: assert property (
    (isaClockDivisorSel == `MBC_ISA_CLOCK_DIVISOR_SEL_DIV4)[*8] |-> isaClk != $past(isaClk, 2))
    else $error("isa clock not divided by four");
  chk_cfg_hold: assert property (
    !$stable({globalMapEnable, ramTypeSelect, isaClockDivisorSel, configValid})
      |-> wrAge <= 3'h4)
    else $error("config output changed without a write");
  chk_bank_onehot: assert property ($onehot0(ramBankSelect))
    else $error("more than one bank selected");
  chk_flash_pair: assert property (
    flashCycle == memoryChipSelect && !(memoryChipSelect && ramBankSelect != 6'h00))
    else $error("flash select and timing disagree");
  chk_idle_no_sel: assert property (
    !$past(memReq) |-> ramBankSelect == 6'h00 && !memoryChipSelect)
    else $error("select without request");
  chk_invalid_off: assert property (
    !configValid [*2] |-> ramBankSelect == 6'h00 && !memoryChipSelect)
    else $error("decode while config invalid");
  chk_disp_invalid: assert property (
    !configValid [*2] |-> displayBufferBase == '0)
    else $error("display base nonzero while invalid");
  cover property (memoryChipSelect);
  cover property (ramBankSelect != 6'h00);
  cover property (globalMapEnable && configValid);
endmodule // mbc_config_regs_props

// ==== memory_bus_config_regs_test.sv ====
// self-checking bench for the memory and bus config registers
`timescale 1ns/1ns
`include "mbc_consts.svh"
module memory_bus_config_regs_test;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = `MBC_HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic memReq = 1'b0;
  logic [26:0] memAddr = 27'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [5:0] ramBankSelect;
  logic [3:0] ramTypeSelect;
  logic [26:0] displayBufferBase;
  logic [1:0] isaClockDivisorSel;
  logic hreadyout, hresp, memoryChipSelect, flashCycle, globalMapEnable, configValid, isaClk;
  int n_errors = 0;
  int num_checks = 0;
  localparam logic [31:0] aClk = 32'(`MBC_IDX_CLOCK_DIVISOR) << `MBC_IDX_SHIFT;
  localparam logic [31:0] aMem = 32'(`MBC_IDX_MEMORY_CONTROL) << `MBC_IDX_SHIFT;
  always #4 core_clk = ~core_clk;
  mbc_config_regs #(.ADDR_W(27)) dut (.core_clk(core_clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .memReq(memReq), .memAddr(memAddr), .ramBankSelect(ramBankSelect),
    .memoryChipSelect(memoryChipSelect), .flashCycle(flashCycle),
    .globalMapEnable(globalMapEnable), .ramTypeSelect(ramTypeSelect),
    .displayBufferBase(displayBufferBase), .configValid(configValid),
    .isaClockDivisorSel(isaClockDivisorSel), .isaClk(isaClk));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one ahb-lite single word transfer
  task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wdat);
    hsel <= 1'b1;
    haddr <= addr;
    hwrite <= wr;
    htrans <= `MBC_HTRANS_NONSEQ;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wdat;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("response", 32'h0, {31'h0, hresp});
  endtask
  // one decode request, result one cycle later
  task automatic dec(input logic [26:0] a, input logic [5:0] sel, input logic cs);
    memReq <= 1'b1;
    memAddr <= a;
    @(posedge core_clk);
    memReq <= 1'b0;
    @(posedge core_clk);
    chk("bank select", {26'h0, sel}, {26'h0, ramBankSelect});
    chk("flash select", {31'h0, cs}, {31'h0, memoryChipSelect});
    chk("flash timing", {31'h0, cs}, {31'h0, flashCycle});
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    bus(1'b0, aClk, 32'h0);
    chk("clock divisor reset", 32'(`MBC_CLKDIV_RESET), rd);
    bus(1'b0, aMem, 32'h0);
    chk("memory control reset", 32'h70, rd);
    chk("type reset", 32'h0, {28'h0, ramTypeSelect});
    chk("map enable reset", 32'h0, {31'h0, globalMapEnable});
    bus(1'b0, 32'h8, 32'h0);
    chk("unmapped read", 32'h0, rd);
    dec(27'h0, 6'h00, 1'b0);
    for (int d = 0; d < 3; d++) begin
      bus(1'b1, aClk, 32'h20 | 32'(d));
      bus(1'b0, aClk, 32'h0);
      chk("clock divisor", 32'h20 | 32'(d), rd);
      repeat (40) @(posedge core_clk);
      chk("divisor select", 32'(d), {30'h0, isaClockDivisorSel});
    end
    for (int b = 0; b < 6; b++) begin
      bus(1'b1, aMem, 32'h81 | 32'(b << 4));
      bus(1'b0, aMem, 32'h0);
      chk("memory control", 32'h81 | 32'(b << 4), rd);
      repeat (3) @(posedge core_clk);
      chk("map enable", 32'h1, {31'h0, globalMapEnable});
      chk("config valid", 32'h1, {31'h0, configValid});
      chk("display base", 32'((b + 1) << 18) - 32'h20000, {5'h0, displayBufferBase});
      dec(27'(b << 18) + 27'h3FFFF, 6'(1 << b), 1'b0);
      dec(27'((b + 1) << 18), 6'h00, 1'b1);
    end
    bus(1'b1, aMem, 32'h17);
    repeat (3) @(posedge core_clk);
    chk("map enable off", 32'h0, {31'h0, globalMapEnable});
    chk("type select", 32'h7, {28'h0, ramTypeSelect});
    dec(27'h100000, 6'h02, 1'b0);
    dec(27'h200000, 6'h00, 1'b0);
    bus(1'b1, aMem, 32'h50);
    repeat (3) @(posedge core_clk);
    chk("reserved type invalid", 32'h0, {31'h0, configValid});
    dec(27'h0, 6'h00, 1'b0);
    final_report();
  end
endmodule // memory_bus_config_regs_test
bind mbc_config_regs mbc_config_regs_props #(.ADDR_W(ADDR_W)) uProps (.core_clk(core_clk),
  .reset(reset), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .memReq(memReq), .ramBankSelect(ramBankSelect), .memoryChipSelect(memoryChipSelect),
  .flashCycle(flashCycle), .globalMapEnable(globalMapEnable), .ramTypeSelect(ramTypeSelect),
  .displayBufferBase(displayBufferBase), .configValid(configValid),
  .isaClockDivisorSel(isaClockDivisorSel), .isaClk(isaClk));
